/* relay_prot_pkg.sv */
// Constants and carrier types for the relay protection controller
package relay_prot_pkg;
  // Clock rate in kHz, period 5 ns
  localparam longint CLK_KHZ = 200000;
  // Level delays as printed, in milliseconds
  localparam longint L1_MS = 60000;
  localparam longint L2_MS = 10000;
  localparam longint L3_MS = 1000;
  localparam longint L4_MS = 20;
  localparam longint L5_MS = 4;
  localparam longint L6_MS = 2;
  // Short-circuit limit is a longest time, so it rounds down
  localparam longint SC_MS = 1;
  localparam longint LOCKOUT_MS = 10000;
  // Cycle counts derived from the printed times
  localparam longint L1_CYC = L1_MS * CLK_KHZ;
  localparam longint L2_CYC = L2_MS * CLK_KHZ;
  localparam longint L3_CYC = L3_MS * CLK_KHZ;
  localparam longint L4_CYC = L4_MS * CLK_KHZ;
  localparam longint L5_CYC = L5_MS * CLK_KHZ;
  localparam longint L6_CYC = L6_MS * CLK_KHZ;
  localparam longint SC_CYC = SC_MS * CLK_KHZ;
  localparam longint LOCKOUT_CYC = LOCKOUT_MS * CLK_KHZ;
  // Thresholds as multiples of rated current, in tenths
  localparam int L1_X10 = 20;
  localparam int L2_X10 = 25;
  localparam int L3_X10 = 30;
  localparam int L4_X10 = 40;
  localparam int L5_X10 = 50;
  localparam int L6_X10 = 60;
  localparam int SC_X10 = 70;
  // Temperature trip and release, degrees C
  localparam int TEMP_TRIP_C = 135;
  localparam int TEMP_CLEAR_C = 130;
  // Short-circuit confirms after a few consecutive samples
  localparam int SC_CONFIRM = 4;
  // Number of timed levels including short-circuit
  localparam int NUM_LEVELS = 7;
  // LED codes, higher is higher priority
  localparam logic [3:0] LED_OFF = 4'h0;
  localparam logic [3:0] LED_UNDERVOLT = 4'h1;
  localparam logic [3:0] LED_OVERTEMP = 4'h2;
  localparam logic [3:0] LED_OC_BASE = 4'h3;
  localparam logic [3:0] LED_SC = 4'h9;
  localparam logic [39:0] TIMER_ZERO = 40'h00_0000_0000;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    ST_NORMAL = 3'b001,
    ST_LOCKOUT = 3'b010,
    ST_WAIT_TOGGLE = 3'b100
  } prot_state_type;

  // Trigger inputs travel together
  typedef struct packed {
    logic main_on;
    logic override_on;
  } trigger_type;

  // Sampled measurements travel together
  typedef struct packed {
    logic sample;
    logic signed [15:0] current;
    logic signed [11:0] temp_c;
  } measure_type;
endpackage : relay_prot_pkg

/* level_timer.sv */
// One over-current level: persistence timer on an above-threshold flag compared outside
`timescale 1ns/100ps
module level_timer
  import relay_prot_pkg::*;
#(
  parameter logic [39:0] DELAY_CYC = 40'h00_0000_0001
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic sample,
  input wire logic above,
  output logic expired
);
  // All state in one struct
  typedef struct packed {
    logic above_q;
    logic [39:0] count;
    logic expired;
  } lt_state_type;

  lt_state_type state;
  lt_state_type next_state;

  // Count while above; drop below restarts timing
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = '0;
    end else begin
      if (sample) begin
        next_state.above_q = above;
      end
      if (!state.above_q) begin
        next_state.count = TIMER_ZERO;
      end else if (state.count < DELAY_CYC) begin
        next_state.count = state.count + 40'h00_0000_0001;
      end
      next_state.expired = state.above_q && (state.count >= DELAY_CYC - 40'h00_0000_0001);
    end
  end

  // Register with clock enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign expired = state.expired;
endmodule : level_timer

/* relay_fault_protection.sv */
// Relay protection controller: current levels, lockout, over-temperature, LED
// What this block does
// - Bidirectional variant protects both current directions
// - Level one: above 2x for 60 s
// - Levels two to six fixed thresholds, delays
// - Short-circuit at 7x trips within 1 ms
// - Levels timed independently; first expiry attributed, highest level if several expire in one cycle
// - Trip opens switch, shows level LED pattern
// - Current limits are fixed constants, not settable
// - 10 s lockout, then main-trigger toggle re-arms
// - Switch opens on trigger request or fault
// - At 135 C open switch, over-temp LED
// - Leave over-temperature below 130 C only
// - Keep tracking triggers and voltage while hot
// - After over-temp, follow present main trigger
// - Under-voltage while hot keeps switch open, unless override
// - LED shows highest-priority active fault
`timescale 1ns/100ps
module relay_fault_protection
  import relay_prot_pkg::*;
#(
  parameter logic BIDIRECTIONAL = 1'b0,
  parameter logic [15:0] MAX_CONTINUOUS_CURRENT = 16'h0064,
  parameter logic [39:0] L1_DELAY = 40'(L1_CYC),
  parameter logic [39:0] L2_DELAY = 40'(L2_CYC),
  parameter logic [39:0] L3_DELAY = 40'(L3_CYC),
  parameter logic [39:0] L4_DELAY = 40'(L4_CYC),
  parameter logic [39:0] L5_DELAY = 40'(L5_CYC),
  parameter logic [39:0] L6_DELAY = 40'(L6_CYC),
  parameter logic [39:0] LOCKOUT_DELAY = 40'(LOCKOUT_CYC)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire trigger_type trig,
  input wire measure_type meas,
  input wire logic undervolt,
  output logic switch_on,
  output logic [3:0] led_code,
  output logic [3:0] trip_level
);
  // Whole controller state
  typedef struct packed {
    prot_state_type mode;
    logic [39:0] lock_count;
    logic [3:0] trip_code;
    logic main_q;
    logic hot;
    logic uv_hot;
    logic [2:0] sc_run;
    logic switch_on;
    logic [3:0] led_code;
  } ctl_state_type;

  ctl_state_type state;
  ctl_state_type next_state;

  // Magnitude seen by protection; reverse flow counts only if bidirectional
  logic [15:0] mag;
  always_comb begin
    if (meas.current < 0) begin
      mag = BIDIRECTIONAL ? 16'(-meas.current) : 16'h0000;
    end else begin
      mag = 16'(meas.current);
    end
  end

  // Tenths of current compared against fixed multiples of rating
  logic [23:0] mag_x10;
  logic [23:0] rated;
  assign mag_x10 = {8'h00, mag} * 24'h00000A;
  assign rated = {8'h00, MAX_CONTINUOUS_CURRENT};

  // Per-level above flags, constants only, never user set
  logic [NUM_LEVELS-1:0] above;
  logic [5:0] expired;
  assign above[0] = mag_x10 > rated * 24'(L1_X10);
  assign above[1] = mag_x10 > rated * 24'(L2_X10);
  assign above[2] = mag_x10 > rated * 24'(L3_X10);
  assign above[3] = mag_x10 > rated * 24'(L4_X10);
  assign above[4] = mag_x10 > rated * 24'(L5_X10);
  assign above[5] = mag_x10 > rated * 24'(L6_X10);
  assign above[6] = mag_x10 > rated * 24'(SC_X10);

  // Timers cleared while tripped so each new run starts fresh
  logic timers_clear;
  assign timers_clear = (state.mode != ST_NORMAL);

  localparam logic [39:0] DELAYS [6] = '{L1_DELAY, L2_DELAY, L3_DELAY,
                                        L4_DELAY, L5_DELAY, L6_DELAY};

  // Six independent level timers
  for (genvar g = 0; g < 6; g++) begin : g_level
    level_timer #(
      .DELAY_CYC(DELAYS[g])
    ) u_timer (
      .clk(clk),
      .arst_n(arst_n),
      .ce(ce),
      .clear(timers_clear),
      .sample(meas.sample),
      .above(above[g]),
      .expired(expired[g])
    );
  end

  // Short-circuit: a few consecutive samples above 7x, well under 1 ms
  logic sc_trip;
  assign sc_trip = (state.sc_run >= 3'(SC_CONFIRM));

  // Highest level that expired wins; short-circuit above all
  logic [3:0] new_trip;
  always_comb begin
    new_trip = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (expired[i]) begin
        new_trip = 4'(i + 1);
      end
    end
    if (sc_trip) begin
      new_trip = 4'h7;
    end
  end

  // Next-state logic
  always_comb begin
    next_state = state;
    next_state.main_q = trig.main_on;
    // Short-circuit persistence on samples
    if (meas.sample) begin
      if (above[6] && state.mode == ST_NORMAL) begin
        next_state.sc_run = (state.sc_run == 3'h7) ? state.sc_run : state.sc_run + 3'h1;
      end else begin
        next_state.sc_run = 3'h0;
      end
      // Temperature with hysteresis
      if (meas.temp_c >= 12'(TEMP_TRIP_C)) begin
        next_state.hot = 1'b1;
      end else if (meas.temp_c < 12'(TEMP_CLEAR_C)) begin
        next_state.hot = 1'b0;
      end
    end
    // Under-voltage seen while hot is remembered
    if (state.hot && undervolt) begin
      next_state.uv_hot = 1'b1;
    end else if (!state.hot && !undervolt) begin
      next_state.uv_hot = 1'b0;
    end
    case (state.mode)
      ST_NORMAL: begin
        if (new_trip != 4'h0) begin
          next_state.mode = ST_LOCKOUT;
          next_state.trip_code = new_trip;
          next_state.lock_count = TIMER_ZERO;
          next_state.sc_run = 3'h0;
        end
      end
      ST_LOCKOUT: begin
        // Triggers ignored for the whole lockout
        if (state.lock_count >= LOCKOUT_DELAY - 40'h00_0000_0001) begin
          next_state.mode = ST_WAIT_TOGGLE;
        end else begin
          next_state.lock_count = state.lock_count + 40'h00_0000_0001;
        end
      end
      ST_WAIT_TOGGLE: begin
        // Only a fresh rising edge re-arms
        if (trig.main_on && !state.main_q) begin
          next_state.mode = ST_NORMAL;
          next_state.trip_code = 4'h0;
        end
      end
      default: begin
        next_state.mode = ST_LOCKOUT;
        next_state.lock_count = TIMER_ZERO;
      end
    endcase
    // Switch follows live trigger unless a fault holds it open
    if (next_state.mode != ST_NORMAL || next_state.hot) begin
      next_state.switch_on = 1'b0;
    end else if (undervolt || state.uv_hot) begin
      next_state.switch_on = trig.main_on && trig.override_on;
    end else begin
      next_state.switch_on = trig.main_on;
    end
    // LED priority: current fault, then temperature, then voltage
    if (next_state.mode != ST_NORMAL) begin
      next_state.led_code = (next_state.trip_code == 4'h7) ? LED_SC
                          : LED_OC_BASE + next_state.trip_code - 4'h1;
    end else if (next_state.hot) begin
      next_state.led_code = LED_OVERTEMP;
    end else if (undervolt) begin
      next_state.led_code = LED_UNDERVOLT;
    end else begin
      next_state.led_code = LED_OFF;
    end
  end

  // State register, frozen while clock enable low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{mode: ST_NORMAL, default: '0};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign switch_on = state.switch_on;
  assign led_code = state.led_code;
  assign trip_level = state.trip_code;

  // Trip forces the switch open next cycle
  property p_trip_opens;
    @(posedge clk) disable iff (!arst_n)
      (ce && state.mode == ST_NORMAL && new_trip != 4'h0) |=> !switch_on;
  endproperty
  a_trip_opens: assert property (p_trip_opens) else $error("trip left switch on");

  // Lockout state never closes the switch
  property p_lock_open;
    @(posedge clk) disable iff (!arst_n)
      (state.mode == ST_LOCKOUT) |-> !switch_on;
  endproperty
  a_lock_open: assert property (p_lock_open) else $error("switch closed in lockout");

  // Re-arm only on rising main trigger
  property p_rearm_edge;
    @(posedge clk) disable iff (!arst_n)
      (ce && state.mode == ST_WAIT_TOGGLE) ##1 (state.mode == ST_NORMAL)
        |-> $past(trig.main_on) && $past(state.main_q, 1) == 1'b0;
  endproperty
  a_rearm_edge: assert property (p_rearm_edge) else $error("re-arm without toggle");

  // Hot keeps switch open
  property p_hot_open;
    @(posedge clk) disable iff (!arst_n)
      state.hot |-> !switch_on;
  endproperty
  a_hot_open: assert property (p_hot_open) else $error("switch on while hot");

  // Hot clears only below release point
  property p_hyst;
    @(posedge clk) disable iff (!arst_n)
      $fell(state.hot) |-> $past(meas.temp_c) < 12'(TEMP_CLEAR_C);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hot cleared above release");

  // Confirmed short-circuit shows trip level 7 and the short-circuit LED on the next cycle
  property p_sc_code;
    @(posedge clk) disable iff (!arst_n)
      (ce && state.mode == ST_NORMAL && sc_trip) |=> trip_level == 4'h7 && led_code == LED_SC;
  endproperty
  a_sc_code: assert property (p_sc_code) else $error("short-circuit not attributed");

  // Reverse current ignored in unidirectional build
  property p_unidir;
    @(posedge clk) disable iff (!arst_n)
      (!BIDIRECTIONAL && meas.current < 0) |-> above == '0;
  endproperty
  a_unidir: assert property (p_unidir) else $error("reverse current counted");

  // Under-voltage while hot blocks close without override
  property p_uv_hold;
    @(posedge clk) disable iff (!arst_n)
      (ce && state.uv_hot && !trig.override_on) |=> !switch_on;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("closed after hot under-voltage");

  // Outside faults the switch follows the trigger seen one edge earlier
  property p_follow;
    @(posedge clk) disable iff (!arst_n)
      (ce && state.mode == ST_NORMAL && new_trip == 4'h0 && !state.hot && !state.uv_hot
        && !undervolt && !(meas.sample && meas.temp_c >= 12'(TEMP_TRIP_C)))
        |=> switch_on == $past(trig.main_on);
  endproperty
  a_follow: assert property (p_follow) else $error("switch not following trigger");

  // A held-open current fault always shows its level and a current pattern
  property p_fault_led;
    @(posedge clk) disable iff (!arst_n)
      (state.mode != ST_NORMAL) |-> trip_level != 4'h0 && led_code >= LED_OC_BASE
        && led_code <= LED_SC;
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("fault pattern not shown");

  // Temperature state moves only on a sample strobe
  property p_sample_only;
    @(posedge clk) disable iff (!arst_n)
      (!meas.sample) |=> $stable(state.hot);
  endproperty
  a_sample_only: assert property (p_sample_only) else $error("hot moved off sample");

  // Wait state reached only after the full lockout count
  property p_lock_len;
    @(posedge clk) disable iff (!arst_n)
      $rose(state.mode == ST_WAIT_TOGGLE)
        |-> $past(state.lock_count) >= LOCKOUT_DELAY - 40'h00_0000_0001;
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("lockout ended early");

  c_trip: cover property (@(posedge clk) state.mode == ST_LOCKOUT);
  c_short: cover property (@(posedge clk) state.mode == ST_LOCKOUT && trip_level == 4'h7);
  c_uv_hot: cover property (@(posedge clk) state.uv_hot && !state.hot);
  c_rearm: cover property (@(posedge clk) state.mode == ST_WAIT_TOGGLE ##1 state.mode == ST_NORMAL);
  c_hot: cover property (@(posedge clk) $fell(state.hot));
endmodule : relay_fault_protection

/* sensor_model.sv */
// Far-side model: trigger switches plus current and temperature sensing
`timescale 1ns/100ps
module sensor_model
  import relay_prot_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic main_req,
  input wire logic ovr_req,
  input wire logic signed [15:0] cur_req,
  input wire logic signed [11:0] temp_req,
  output trigger_type trig,
  output measure_type meas
);
  // Sample strobe phase, one pulse every second cycle
  logic phase;

  // Converter output refreshed each cycle, strobe marks valid samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 1'b0;
      meas <= '0;
      trig <= '0;
    end else begin
      phase <= ~phase;
      meas.sample <= phase;
      meas.current <= cur_req;
      meas.temp_c <= temp_req;
      // Switches follow the user, a re-arm needs a real release and press
      trig.main_on <= main_req;
      trig.override_on <= ovr_req;
    end
  end
endmodule : sensor_model

/* tb.sv */
// Self-checking bench for the relay protection controller
`timescale 1ns/100ps
module tb;
  import relay_prot_pkg::*;
  // One ordinary case: current step and level it should trip
  typedef struct packed {
    logic signed [15:0] cur;
    logic [3:0] lvl;
  } row_type;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic main_req = 1'b0;
  logic ovr_req = 1'b0;
  logic undervolt = 1'b0;
  logic signed [15:0] cur_req = 16'h0000;
  logic signed [11:0] temp_req = 12'h019;
  trigger_type trig;
  measure_type meas;
  logic switch_on;
  logic [3:0] led_code;
  logic [3:0] trip_level;
  int err_total = 0;
  int n_tests = 0;
  int n;
  // Rating 100: thresholds 200, 250 ... 700, strict greater-than
  row_type rows [9] = '{'{16'h00C9, 4'h1}, '{16'h00C8, 4'h0}, '{16'h00FB, 4'h2},
    '{16'h012D, 4'h3}, '{16'h0191, 4'h4}, '{16'h01F5, 4'h5}, '{16'h0259, 4'h6},
    '{16'h02BD, 4'h7}, '{16'hFD43, 4'h0}};
  // Shortened delays in cycles, levels one to six then lockout
  localparam logic [39:0] SHORT_DLY [7] = '{40'h00_0000_005A, 40'h00_0000_0050,
    40'h00_0000_0046, 40'h00_0000_003C, 40'h00_0000_0032, 40'h00_0000_0028,
    40'h00_0000_0064};

  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;

  sensor_model u_sensor_model (.clk(clk), .arst_n(arst_n), .main_req(main_req),
    .ovr_req(ovr_req), .cur_req(cur_req), .temp_req(temp_req), .trig(trig), .meas(meas));

  // Shortened delays keep the run short; level six still far slower than the short
  relay_fault_protection #(.L1_DELAY(SHORT_DLY[0]), .L2_DELAY(SHORT_DLY[1]),
    .L3_DELAY(SHORT_DLY[2]), .L4_DELAY(SHORT_DLY[3]),
    .L5_DELAY(SHORT_DLY[4]), .L6_DELAY(SHORT_DLY[5]),
    .LOCKOUT_DELAY(SHORT_DLY[6])) u_relay_fault_protection (.clk(clk),
    .arst_n(arst_n), .ce(ce), .trig(trig), .meas(meas), .undervolt(undervolt),
    .switch_on(switch_on), .led_code(led_code), .trip_level(trip_level));

  // Delay in cycles for each level, matching the overrides above
  function automatic int dly(input logic [3:0] l);
    if (l >= 4'h1 && l <= 4'h6) begin
      dly = int'(SHORT_DLY[l - 4'h1]);
    end else begin
      dly = 0;
    end
  endfunction : dly

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Compare a 4-bit result
  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk4

  // Compare a 1-bit result
  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  // Bounded wait on switch state; a hang ends the run as a mismatch
  task automatic wait_sw(input logic val, input int bound, output int cnt);
    for (cnt = 1; cnt <= bound; cnt++) begin
      @(negedge clk);
      if (switch_on === val) return;
    end
    err_total++;
    $display("[FAIL] switch_on wait expected %b seen %b", val, switch_on);
    wrap_up();
  endtask : wait_sw

  // Reset held for 12 cycles, then main trigger closes the switch
  task automatic start();
    @(posedge clk);
    arst_n <= 1'b0;
    cur_req <= 16'h0000;
    temp_req <= 12'h019;
    main_req <= 1'b1;
    ovr_req <= 1'b0;
    undervolt <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    wait_sw(1'b1, 6, n);
  endtask : start

  // Set temperature, then let a few samples land
  task automatic heat(input logic signed [11:0] t);
    @(posedge clk);
    temp_req <= t;
    repeat (8) @(negedge clk);
  endtask : heat

  // Main sequence
  initial begin
    for (int i = 0; i < 9; i++) begin
      start();
      @(posedge clk);
      cur_req <= rows[i].cur;
      if (rows[i].lvl == 4'h0) begin
        repeat (200) @(negedge clk);
        chk1("switch_on", 1'b1, switch_on);
      end else begin
        wait_sw(1'b0, 200, n);
        chk1("trip_time", 1'b1, n >= dly(rows[i].lvl) && n <= dly(rows[i].lvl) + 12);
        chk4("trip_level", rows[i].lvl, trip_level);
        chk4("led_code", rows[i].lvl == 4'h7 ? LED_SC : LED_OC_BASE + rows[i].lvl - 4'h1,
          led_code);
      end
    end
    // Lockout: presses inside it and a held trigger after it are refused
    start();
    @(posedge clk);
    cur_req <= 16'h02BD;
    wait_sw(1'b0, 20, n);
    @(posedge clk);
    cur_req <= 16'h0000;
    repeat (20) @(posedge clk);
    main_req <= 1'b0;
    repeat (4) @(posedge clk);
    main_req <= 1'b1;
    repeat (130) @(negedge clk);
    chk1("switch_on", 1'b0, switch_on);
    @(posedge clk);
    main_req <= 1'b0;
    repeat (4) @(posedge clk);
    main_req <= 1'b1;
    wait_sw(1'b1, 8, n);
    chk4("led_code", LED_OFF, led_code);
    // Level one timer restarts when current dips below threshold
    @(posedge clk);
    cur_req <= 16'h00C9;
    repeat (60) @(posedge clk);
    cur_req <= 16'h0000;
    repeat (6) @(posedge clk);
    cur_req <= 16'h00C9;
    repeat (80) @(negedge clk);
    chk1("switch_on", 1'b1, switch_on);
    wait_sw(1'b0, 40, n);
    chk4("trip_level", 4'h1, trip_level);
    // Over-temperature, hysteresis, and following the present trigger
    start();
    heat(12'h087);
    chk1("switch_on", 1'b0, switch_on);
    chk4("led_code", LED_OVERTEMP, led_code);
    @(posedge clk);
    main_req <= 1'b0;
    heat(12'h084);
    chk1("switch_on", 1'b0, switch_on);
    heat(12'h081);
    chk1("switch_on", 1'b0, switch_on);
    chk4("led_code", LED_OFF, led_code);
    @(posedge clk);
    main_req <= 1'b1;
    wait_sw(1'b1, 6, n);
    @(posedge clk);
    main_req <= 1'b0;
    wait_sw(1'b0, 6, n);
    // Clock enable low freezes the controller against a trigger press
    @(posedge clk);
    ce <= 1'b0;
    main_req <= 1'b1;
    repeat (6) @(negedge clk);
    chk1("switch_on", 1'b0, switch_on);
    @(posedge clk);
    ce <= 1'b1;
    wait_sw(1'b1, 4, n);
    // Under-voltage appearing while hot, priority of LED patterns
    start();
    heat(12'h08C);
    @(posedge clk);
    undervolt <= 1'b1;
    heat(12'h08C);
    chk4("led_code", LED_OVERTEMP, led_code);
    heat(12'h07D);
    chk1("switch_on", 1'b0, switch_on);
    chk4("led_code", LED_UNDERVOLT, led_code);
    @(posedge clk);
    ovr_req <= 1'b1;
    wait_sw(1'b1, 6, n);
    wrap_up();
  end
endmodule : tb
